// File: logic/mstp_top.sv
// master interval channel plus one-count slave channel driving one pwm pin
`include "mstp_cfg.svh"
module mstp_top #(
	parameter int                        CNT_W      = `MSTP_CNT_W,
	parameter logic [CNT_W-1:0]          PERIOD_CYC = CNT_W'(`MSTP_PERIOD_CYC)
) (
	input  wire logic                    CLOCK,
	input  wire logic                    RST,
	input  wire mstp_pkg::mstp_trig_t    START_TRIG,
	input  wire mstp_pkg::mstp_trig_t    STOP_TRIG,
	input  wire mstp_pkg::mstp_out_cfg_t OUT_CFG,
	input  wire logic                    INTERVAL_WR,
	input  wire logic [CNT_W-1:0]        INTERVAL_DATA,
	input  wire logic                    SLAVE_WIDTH_WR,
	input  wire logic [CNT_W-1:0]        SLAVE_WIDTH_DATA,
	input  wire logic                    INDICATOR_WR,
	input  wire logic                    INDICATOR_DATA,
	output logic                         PWM_PORT_PIN,
	output logic                         MASTER_INTERVAL_IRQ,
	output logic                         RUNNING,
	output logic                         INDICATOR_PORT_PIN
);
	import mstp_pkg::*;

	mstp_state_t       state_reg;        // both channels idle or counting
	logic [CNT_W-1:0]  interval_reg;     // master reload value, period minus one
	logic [CNT_W-1:0]  slave_width_reg;  // slave data register, active cycles
	logic [CNT_W-1:0]  mcnt_reg;         // master down counter
	logic [CNT_W-1:0]  scnt_reg;         // slave down counter
	logic              active_reg;       // slave output at active level
	logic              pin_reg;          // registered pin level
	logic              irq_reg;          // one-cycle interval interrupt
	logic              ind_reg;          // indicator port latch
	logic              start_ev;         // joint start accepted
	logic              stop_ev;          // either stop bit stops the pair
	logic              period_end;       // master reaches zero while running
	logic              period_start;     // new period begins

	// a default width of 90 percent of the default period
	function automatic logic [CNT_W-1:0] pct_of(input logic [CNT_W-1:0] cyc,
		input int unsigned pct);
		logic [CNT_W+7:0] prod;
		prod = (CNT_W+8)'(cyc) * (CNT_W+8)'(pct);
		return CNT_W'(prod / (CNT_W+8)'(100));
	endfunction

	// only the pair of bits starts: one lone bit would leave the slave unsynced
	// a stop in the same cycle cancels the start, so the pair never runs half-loaded
	assign start_ev     = (state_reg == MSTP_IDLE) && START_TRIG.master && START_TRIG.slave
		&& !stop_ev;
	assign stop_ev      = STOP_TRIG.master || STOP_TRIG.slave;
	assign period_end   = (state_reg == MSTP_RUN) && (mcnt_reg == '0);
	assign period_start = start_ev || (period_end && !stop_ev);

	// run state of the channel pair
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_reg <= MSTP_IDLE;
		end else begin
			case (state_reg)
				MSTP_IDLE: begin
					if (start_ev) begin
						state_reg <= MSTP_RUN;
					end
				end
				MSTP_RUN: begin
					if (stop_ev) begin
						state_reg <= MSTP_IDLE;
					end
				end
				default: begin
					state_reg <= MSTP_IDLE;
				end
			endcase
		end
	end

	// master interval register, reset loads it for a 2 ms period, software may rewrite it
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			interval_reg <= PERIOD_CYC - CNT_W'(1);
		end else if (INTERVAL_WR) begin
			interval_reg <= INTERVAL_DATA;
		end
	end

	// slave data register; taken at the next period start, not mid-pulse
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			slave_width_reg <= pct_of(PERIOD_CYC, `MSTP_WIDTH_PCT);
		end else if (SLAVE_WIDTH_WR) begin
			slave_width_reg <= SLAVE_WIDTH_DATA;
		end
	end

	// master counter: interval+1 cycles per period, reloaded at zero
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			mcnt_reg <= '0;
		end else if (period_start) begin
			mcnt_reg <= interval_reg;
		end else if (state_reg == MSTP_RUN) begin
			mcnt_reg <= mcnt_reg - CNT_W'(1);
		end
	end

	// interval interrupt, one pulse per period
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			irq_reg <= 1'h0;
		end else begin
			irq_reg <= period_end && !stop_ev;
		end
	end

	// slave one-count: reload at period start, drop active when count runs out
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			scnt_reg   <= '0;
			active_reg <= 1'h0;
		end else if (stop_ev) begin
			scnt_reg   <= '0;
			active_reg <= 1'h0;
		end else if (period_start) begin
			scnt_reg   <= slave_width_reg;
			active_reg <= (slave_width_reg != '0);
		end else if (active_reg) begin
			scnt_reg <= scnt_reg - CNT_W'(1);
			if (scnt_reg == CNT_W'(1)) begin
				active_reg <= 1'h0;
			end
		end
	end

	// pin level: initial value while idle, else slave state mapped by polarity
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pin_reg <= `MSTP_INIT_LEVEL_RST;
		end else if (state_reg == MSTP_IDLE) begin
			pin_reg <= OUT_CFG.init_level;
		end else begin
			pin_reg <= active_reg ^ OUT_CFG.active_low;
		end
	end

	// indicator output port, software writes its level
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ind_reg <= `MSTP_IND_RST;
		end else if (INDICATOR_WR) begin
			ind_reg <= INDICATOR_DATA;
		end
	end

	assign PWM_PORT_PIN        = pin_reg;
	assign MASTER_INTERVAL_IRQ = irq_reg;
	assign RUNNING             = (state_reg == MSTP_RUN);
	assign INDICATOR_PORT_PIN  = ind_reg;

	// named steps of a period
	sequence seq_period_wrap;
		period_end && !stop_ev;
	endsequence
	sequence seq_new_period;
		period_start && (slave_width_reg != '0);
	endsequence

	master_reload_a: assert property (@(posedge CLOCK) disable iff (RST)
		seq_period_wrap |=> (mcnt_reg == $past(interval_reg)))
		else $error("master did not reload its interval");
	interval_irq_a: assert property (@(posedge CLOCK) disable iff (RST)
		seq_period_wrap |=> MASTER_INTERVAL_IRQ ##1 !MASTER_INTERVAL_IRQ)
		else $error("interval interrupt not a single pulse at period end");
	slave_load_a: assert property (@(posedge CLOCK) disable iff (RST)
		seq_new_period |=> (scnt_reg == $past(slave_width_reg)) && active_reg)
		else $error("slave did not take the width register");
	slave_end_a: assert property (@(posedge CLOCK) disable iff (RST)
		active_reg && (scnt_reg == CNT_W'(1)) && !period_start |=> !active_reg)
		else $error("slave output did not end at count done");
	slave_count_a: assert property (@(posedge CLOCK) disable iff (RST)
		active_reg && (scnt_reg > CNT_W'(1)) && !stop_ev && !period_start
		|=> active_reg && (scnt_reg == $past(scnt_reg) - CNT_W'(1)))
		else $error("slave count did not step down");
	active_low_a: assert property (@(posedge CLOCK) disable iff (RST)
		RUNNING && active_reg |=> (PWM_PORT_PIN == !$past(OUT_CFG.active_low)))
		else $error("active pin level wrong for polarity");
	init_level_a: assert property (@(posedge CLOCK) disable iff (RST)
		!RUNNING |=> (PWM_PORT_PIN == $past(OUT_CFG.init_level)))
		else $error("idle pin not at initial level");
	joint_start_a: assert property (@(posedge CLOCK) disable iff (RST)
		$rose(RUNNING) |-> $past(START_TRIG.master) && $past(START_TRIG.slave))
		else $error("channels started without both trigger bits");
	start_load_a: assert property (@(posedge CLOCK) disable iff (RST)
		start_ev && (slave_width_reg != '0) |=> active_reg ##1 (PWM_PORT_PIN == !OUT_CFG.active_low))
		else $error("start did not drive the active level");

	// master counts down by one each running cycle between wraps
	master_step_a: assert property (@(posedge CLOCK) disable iff (RST)
		RUNNING && (mcnt_reg != '0) && !stop_ev |=> (mcnt_reg == $past(mcnt_reg) - CNT_W'(1)))
		else $error("master count did not step down");
	// a start loads the interval at once, so the first period is a full one
	start_reload_a: assert property (@(posedge CLOCK) disable iff (RST)
		start_ev |=> RUNNING && (mcnt_reg == $past(interval_reg)))
		else $error("start did not load the master interval");
	// the interrupt never shows without a period wrap behind it
	irq_source_a: assert property (@(posedge CLOCK) disable iff (RST)
		MASTER_INTERVAL_IRQ |-> $past(period_end) && !$past(stop_ev))
		else $error("interval interrupt without a period wrap");
	// a lone start bit leaves the pair idle
	lone_bit_a: assert property (@(posedge CLOCK) disable iff (RST)
		!RUNNING && (START_TRIG.master != START_TRIG.slave) |=> !RUNNING)
		else $error("one start bit alone started the channels");
	// either stop bit halts both channels and ends the pulse
	stop_pair_a: assert property (@(posedge CLOCK) disable iff (RST)
		RUNNING && stop_ev |=> !RUNNING && !active_reg && !MASTER_INTERVAL_IRQ)
		else $error("stop did not halt both channels");
	// a zero width never reaches the active level
	zero_width_a: assert property (@(posedge CLOCK) disable iff (RST)
		period_start && (slave_width_reg == '0) |=> !active_reg)
		else $error("zero width still drove the active level");
	// while idle nothing counts and nothing interrupts
	idle_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
		!RUNNING |-> !active_reg && !MASTER_INTERVAL_IRQ)
		else $error("idle channels still active");
	// while running the pin is the slave state seen through the polarity
	pin_follow_a: assert property (@(posedge CLOCK) disable iff (RST)
		RUNNING |=> (PWM_PORT_PIN == ($past(active_reg) ^ $past(OUT_CFG.active_low))))
		else $error("running pin does not follow slave state");
endmodule

// File: inc/mstp_cfg.svh
// timing constants and reset values for the master/slave timer pwm block
`ifndef MSTP_CFG_SVH
`define MSTP_CFG_SVH
`define MSTP_CLK_MHZ         100
`define MSTP_PERIOD_US       2000
`define MSTP_PERIOD_CYC      (`MSTP_PERIOD_US * `MSTP_CLK_MHZ)
`define MSTP_WIDTH_PCT       90
`define MSTP_CNT_W           18
`define MSTP_INIT_LEVEL_RST  1'h1
`define MSTP_ACTIVE_LOW_RST  1'h1
`define MSTP_IND_RST         1'h0
`endif

// File: inc/mstp_pkg.sv
// types shared by the master/slave timer pwm block
package mstp_pkg;
	// start or stop trigger bits of the two channels, written in one go
	typedef struct packed {
		logic master;
		logic slave;
	} mstp_trig_t;
	// output pin configuration
	typedef struct packed {
		logic active_low;
		logic init_level;
	} mstp_out_cfg_t;
	// channel run state
	typedef enum logic {MSTP_IDLE, MSTP_RUN} mstp_state_t;
endpackage

// File: test/mstp_lamp_model.sv
// lamp model hanging off the pwm pin, counts its lit cycles
module mstp_lamp_model (
	input  wire logic   clock,
	input  wire logic   rst,
	input  wire logic   pin_n,
	output int unsigned lit_cycles
);
	timeunit 1ns;
	timeprecision 1ns;
	// lamp sinks current into the pin, so it glows only on a low level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lit_cycles <= 0;
		end else if (pin_n === 1'h0) begin
			lit_cycles <= lit_cycles + 1;
		end
	end
endmodule

// File: test/mstp_top_tb.sv
// self-checking bench for the master/slave timer pwm block
module mstp_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 20; // short period keeps the run small
	logic                   clk, rst, iwr, swr, dwr, ddat;
	logic [17:0]            idat, sdat;
	mstp_pkg::mstp_trig_t   st, sp;
	mstp_pkg::mstp_out_cfg_t cfg;
	logic                   pin, irq, run, ind;
	int unsigned            lit, cyc, err_total, check_count, dc, dl, w, l0;
	// polarity, duty and the lit cycles one period should show; 90% wraps back to 10%
	typedef struct packed {logic al; int pct; int lit;} mstp_row_t;
	mstp_row_t rows [8] = '{'{1'h1, 10, 2}, '{1'h1, 30, 6}, '{1'h1, 50, 10},
		'{1'h1, 70, 14}, '{1'h1, 90, 18}, '{1'h1, 10, 2}, '{1'h1, 0, 0},
		'{1'h0, 30, 14}};
	mstp_top #(.PERIOD_CYC(18'h14)) u_dut (.CLOCK(clk), .RST(rst), .START_TRIG(st),
		.STOP_TRIG(sp), .OUT_CFG(cfg), .INTERVAL_WR(iwr), .INTERVAL_DATA(idat),
		.SLAVE_WIDTH_WR(swr), .SLAVE_WIDTH_DATA(sdat), .INDICATOR_WR(dwr),
		.INDICATOR_DATA(ddat), .PWM_PORT_PIN(pin), .MASTER_INTERVAL_IRQ(irq),
		.RUNNING(run), .INDICATOR_PORT_PIN(ind));
	mstp_lamp_model u_lamp (.clock(clk), .rst(rst), .pin_n(pin), .lit_cycles(lit));
	// free cycle count, used to time the interrupt spacing
	always @(posedge clk) cyc <= cyc + 1;
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// bounded wait for the next interrupt pulse; a lost pulse ends the run
	task wait_irq;
		int n;
		n = 0;
		@(negedge clk);
		while (irq !== 1'h1) begin
			n++;
			if (n > 4 * P) begin
				err_total++;
				wrap_up();
			end
			@(negedge clk);
		end
	endtask
	// one full period between two interrupts: its length and lit cycles
	task measure;
		int unsigned c0;
		wait_irq();
		c0 = cyc;
		l0 = lit;
		wait_irq();
		dc = cyc - c0;
		dl = lit - l0;
	endtask
	initial begin
		rst = 1'h1;
		st = 2'h0;
		sp = 2'h0;
		cfg = 2'h3;
		{iwr, swr, dwr, ddat} = 4'h0;
		idat = 18'h13;
		sdat = 18'h0;
		{err_total, check_count, cyc} = 0;
		repeat (3) @(negedge clk);
		chk(pin, 1'h1);
		chk({irq, run, ind}, 3'h0);
		rst = 1'h0;
		iwr = 1'h1; // software programs the period
		@(negedge clk);
		iwr = 1'h0;
		st = 2'h2; // master bit alone must be ignored
		repeat (2) @(negedge clk);
		chk(run, 1'h0);
		chk(pin, 1'h1);
		st = 2'h3;
		@(negedge clk);
		st = 2'h0;
		@(negedge clk);
		chk(run, 1'h1);
		measure();
		chk(dc, P);
		chk(dl, P * 90 / 100);
		$display("start and reset width done");
		// new width only counts from the next period start, so skip one
		foreach (rows[i]) begin
			w = P * rows[i].pct / 100;
			cfg.active_low = rows[i].al;
			sdat = w[17:0];
			swr = 1'h1;
			@(negedge clk);
			swr = 1'h0;
			wait_irq();
			measure();
			chk(dc, P);
			chk(dl, rows[i].lit);
		end
		$display("duty table done");
		// indicator written high then back low, once after the duty table
		ddat = 1'h1;
		dwr = 1'h1;
		@(negedge clk);
		ddat = 1'h0;
		chk(ind, 1'h1);
		@(negedge clk);
		dwr = 1'h0;
		chk(ind, 1'h0);
		sp = 2'h1;
		@(negedge clk);
		sp = 2'h0;
		@(negedge clk);
		chk(run, 1'h0);
		chk(pin, 1'h1);
		l0 = lit;
		repeat (2 * P) @(negedge clk);
		chk(lit - l0, 0);
		$display("indicator and stop done");
		// reset in mid-run sets the pin high and drops irq, run and ind at once; reset values then give a 90% period
		cfg = 2'h3;
		st = 2'h3;
		@(negedge clk);
		st = 2'h0;
		repeat (P / 2) @(negedge clk);
		chk(run, 1'h1);
		rst = 1'h1;
		@(negedge clk);
		chk({pin, irq, run, ind}, 4'h8);
		rst = 1'h0;
		@(negedge clk);
		chk(pin, 1'h1);
		chk(run, 1'h0);
		st = 2'h3;
		@(negedge clk);
		st = 2'h0;
		measure();
		chk(dc, P);
		chk(dl, P * 90 / 100);
		$display("mid-run reset done");
		wrap_up();
	end
endmodule
